//--- src/serial_adapter_pkg.sv
// constants, field layouts and carrier types of the serial adapter
// assumes a single 40 MHz clock and bus pins sampled on that clock
package serial_adapter_pkg;

	// ****************************************************************
	// register select and bus
	// ****************************************************************
	localparam logic SEL_CTRL_STATUS = 1'b0;
	localparam logic SEL_DATA = 1'b1;
	localparam logic DIR_WRITE = 1'b0;
	localparam logic DIR_READ = 1'b1;
	localparam int DATA_W = 8;
	localparam int FIFO_DEPTH = 16;
	localparam int CLK_PERIOD_NS = 25;

	// ****************************************************************
	// control fields
	// ****************************************************************
	localparam logic [1:0] DIV_1 = 2'h0;
	localparam logic [1:0] DIV_16 = 2'h1;
	localparam logic [1:0] DIV_64 = 2'h2;
	localparam logic [1:0] DIV_MRESET = 2'h3;
	localparam logic [6:0] LIMIT_1 = 7'h00;
	localparam logic [6:0] LIMIT_16 = 7'h0f;
	localparam logic [6:0] LIMIT_64 = 7'h3f;
	localparam logic [1:0] TXC_LOW_OFF = 2'h0;
	localparam logic [1:0] TXC_LOW_IRQ = 2'h1;
	localparam logic [1:0] TXC_HIGH_OFF = 2'h2;
	localparam logic [1:0] TXC_BREAK = 2'h3;
	localparam logic [2:0] FMT_7E2 = 3'h0;
	localparam logic [2:0] FMT_7O2 = 3'h1;
	localparam logic [2:0] FMT_8N2 = 3'h4;
	localparam logic [2:0] FMT_8N1 = 3'h5;
	localparam logic [7:0] CONTROL_RESET = 8'h03;
	localparam logic [7:0] MASK_7BIT = 8'h7f;
	localparam logic [3:0] BITS_7 = 4'h7;
	localparam logic [3:0] BITS_8 = 4'h8;
	localparam logic [1:0] STOP_ONE = 2'h1;
	localparam logic [1:0] STOP_TWO = 2'h2;

	typedef struct packed {
		logic rx_interrupt_enable;
		logic [1:0] tx_control;
		logic [2:0] format_select;
		logic [1:0] divide_select;
	} control_t;

	typedef struct packed {
		logic irq;
		logic parity_error_flag;
		logic overrun_flag;
		logic framing_error_flag;
		logic clear_to_send;
		logic carrier_loss;
		logic transmit_empty_flag;
		logic receive_full_flag;
	} status_t;

	typedef struct packed {
		logic chip_sel;
		logic register_select;
		logic read_write;
		logic enable;
		logic [7:0] wdata;
	} bus_t;

	typedef struct packed {
		logic word8;
		logic par_en;
		logic par_odd;
		logic stop2;
	} frame_t;

	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY,
		RX_STOP} rx_state_t;
	typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PARITY,
		TX_STOP} tx_state_t;

	function automatic frame_t decode_format(logic [2:0] f);
		frame_t d;
		d.word8 = f[2];
		d.par_en = !(f == FMT_8N2 || f == FMT_8N1);
		d.par_odd = f[0];
		d.stop2 = (f == FMT_7E2 || f == FMT_7O2 || f == FMT_8N2);
		return d;
	endfunction

endpackage

//--- src/adapter_fifo.sv
// synchronous fifo holding characters written for transmission
// assumes one clock; clear empties it at once
`timescale 1ns/10ps
`default_nettype none
module adapter_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic clk, // system clock
	input wire logic rst_b, // async reset, active low
	input wire logic clear, // synchronous flush
	input wire logic in_valid, // push request
	output logic in_ready, // room for a word
	input wire logic [WIDTH-1:0] in_data, // pushed word
	output logic out_valid, // a word is held
	input wire logic out_ready, // pop request
	output logic [WIDTH-1:0] out_data // oldest word
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wptr;
		logic [AW-1:0] rptr;
		logic [AW:0] count;
	} fifo_state_t;
	fifo_state_t r, s;
	logic push, pop;

	assign in_ready = r.count != (AW+1)'(DEPTH);
	assign out_valid = r.count != '0;
	assign out_data = r.mem[r.rptr];

	always_comb begin
		s = r;
		push = in_valid && in_ready;
		pop = out_ready && out_valid;
		if (push) begin
			s.mem[r.wptr] = in_data;
			s.wptr = (r.wptr == AW'(DEPTH-1)) ? '0 : r.wptr + 1'b1;
		end
		if (pop)
			s.rptr = (r.rptr == AW'(DEPTH-1)) ? '0 : r.rptr + 1'b1;
		s.count = r.count + (AW+1)'(push) - (AW+1)'(pop);
		if (clear) begin
			s.wptr = '0;
			s.rptr = '0;
			s.count = '0;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			r <= '0;
		else
			r <= s;
	end
endmodule
`default_nettype wire

//--- src/bit_timer.sv
// turns edges of an external bit clock into one-cycle bit enables
// assumes tick is a one-cycle pulse per external clock edge
`timescale 1ns/10ps
`default_nettype none
module bit_timer (
	input wire logic clk, // system clock
	input wire logic rst_b, // async reset, active low
	input wire logic tick, // external clock edge seen
	input wire logic restart, // realign to half a bit
	input wire logic [1:0] div, // divide ratio code
	output logic bit_en // one pulse per bit time
);
	import serial_adapter_pkg::*;
	typedef struct packed {
		logic [6:0] cnt;
	} timer_state_t;
	timer_state_t r, s;
	logic [6:0] limit;

	always_comb begin
		s = r;
		case (div)
			DIV_16: limit = LIMIT_16;
			DIV_64: limit = LIMIT_64;
			default: limit = LIMIT_1;
		endcase
		bit_en = 1'b0;
		if (restart) begin
			// first pulse lands half a bit later, mid cell
			s.cnt = 7'((limit + 7'h01) >> 1);
		end else if (tick) begin
			if (r.cnt >= limit) begin
				bit_en = 1'b1;
				s.cnt = '0;
			end else begin
				s.cnt = r.cnt + 7'h01;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			r <= '0;
		else
			r <= s;
	end
endmodule
`default_nettype wire

//--- src/async_serial_adapter.sv
// control and status logic of an asynchronous serial adapter,
// with its transmitter, receiver and a transmit fifo
// assumes bus, bit clocks and modem inputs are synchronous to clk
`timescale 1ns/10ps
`default_nettype none

// Contract
// - rs low and read/write low on an access writes the control register.
// - divide field 00 /1, 01 /16, 10 /64, 11 master reset.
// - master reset clears flags but cts/carrier, resets rx/tx, keeps control.
// - format field picks word length, parity and stop bit count.
// - format changes act immediately, no end of character wait.
// - tx control 00/01/10 set request pin and transmit interrupt.
// - tx control 11 drives request low, sends break, no tx interrupt.
// - control bit 7 enables receive full, overrun, carrier loss irqs.
// - rs low and read/write high reads the status register.
// - receive full sets on transfer; read, reset, carrier loss clear.
// - transmit empty is low from a write until transmission starts.
// - carrier loss latches on rise; cleared by status then data read.
// - if carrier still lost after clearing, flag follows input, no irq.
// - cts status mirrors input, high inhibits transmit empty.
// - framing error from missing first stop, kept with character.
// - overrun at last bit of second unread character, shown after read.
// - overrun keeps receive full; cleared by data read or reset.
// - parity error on mismatch, held; no parity means no check.
// - status bit 7 equals the active interrupt output.
// - data read or data write clears the interrupt request.
// - seven bit formats read msb zero and ignore written msb.
// - data write is taken on enable falling with rs high, write.
// - a full receive register blocks transfer of a new character.
// - tx interrupt when tx control is 01 and transmit empty.
// - carrier loss high holds the receiver idle and initialised.
module async_serial_adapter #(
	parameter int DEPTH = serial_adapter_pkg::FIFO_DEPTH
) (
	input wire logic clk, // 40 MHz system clock
	input wire logic rst_b, // async reset, active low
	input wire serial_adapter_pkg::bus_t bus, // processor bus pins
	output logic [7:0] data_out, // read data
	output logic data_oe, // read data drive enable
	output logic irq_b, // interrupt request, active low
	output logic request_to_send_b, // request pin level
	output logic tx_line, // serial transmit data
	input wire logic rx_line, // serial receive data
	input wire logic tx_clk, // transmit bit clock
	input wire logic rx_clk, // receive bit clock
	input wire logic clear_to_send_b, // modem clear to send, low = clear
	input wire logic carrier_loss // high = carrier not present
);
	import serial_adapter_pkg::*;

	// ****************************************************************
	// state
	// ****************************************************************
	typedef struct packed {
		control_t ctl;
		logic en_d;
		logic txclk_d;
		logic rxclk_d;
		logic dcd_d;
		logic rx_full;
		logic fe;
		logic pe;
		logic ovr;
		logic ovr_pend;
		logic dcd_lat;
		logic dcd_armed;
		logic [7:0] receive_holding_reg;
		rx_state_t rx_st;
		logic [3:0] rx_cnt;
		logic [7:0] rx_sh;
		logic rx_par;
		tx_state_t tx_st;
		logic [3:0] tx_cnt;
		logic [7:0] tx_sh;
		logic tx_par;
		logic txd;
		logic tx_out;
		logic [7:0] dout;
		logic doe;
		logic irq_b;
		logic rts_b;
	} state_t;

	localparam state_t STATE_RESET = '{ctl: control_t'(CONTROL_RESET),
		rx_st: RX_IDLE, tx_st: TX_IDLE, txd: 1'b1, tx_out: 1'b1,
		irq_b: 1'b1, default: '0};

	state_t r, s;
	frame_t frm;
	status_t st;
	logic mres, acc, wr_ctl, wr_tdr, rd_stat, rd_rdr;
	logic tx_tick, rx_tick, tx_bit_en, rx_bit_en, rx_restart, rx_hold;
	logic fifo_ready, fifo_valid, fifo_pop, stop_done, tx_load;
	logic [7:0] fifo_data, wmasked, rx_word;
	logic [3:0] nbits;

	// ****************************************************************
	// helpers
	// ****************************************************************
	assign mres = r.ctl.divide_select == DIV_MRESET;
	assign frm = decode_format(r.ctl.format_select);
	assign nbits = frm.word8 ? BITS_8 : BITS_7;
	assign acc = r.en_d && !bus.enable && bus.chip_sel;
	assign wr_ctl = acc && bus.register_select == SEL_CTRL_STATUS &&
		bus.read_write == DIR_WRITE;
	assign wr_tdr = acc && bus.register_select == SEL_DATA &&
		bus.read_write == DIR_WRITE;
	assign rd_stat = acc && bus.register_select == SEL_CTRL_STATUS &&
		bus.read_write == DIR_READ;
	assign rd_rdr = acc && bus.register_select == SEL_DATA &&
		bus.read_write == DIR_READ;
	assign tx_tick = r.txclk_d && !tx_clk;
	assign rx_tick = !r.rxclk_d && rx_clk;
	// seven bit formats drop the written msb
	assign wmasked = frm.word8 ? bus.wdata : (bus.wdata & MASK_7BIT);
	assign rx_hold = mres || carrier_loss;
	assign rx_restart = rx_hold || r.rx_st == RX_IDLE;
	assign rx_word = frm.word8 ? r.rx_sh : {1'b0, r.rx_sh[7:1]};
	assign stop_done = r.tx_st == TX_STOP &&
		(!frm.stop2 || r.tx_cnt == {2'b00, STOP_TWO});
	assign tx_load = tx_bit_en && !mres && fifo_valid &&
		(r.tx_st == TX_IDLE || stop_done);
	assign fifo_pop = tx_load;

	// ****************************************************************
	// submodules
	// ****************************************************************
	adapter_fifo #(.WIDTH(DATA_W), .DEPTH(DEPTH)) u_fifo (
		.clk(clk),
		.rst_b(rst_b),
		.clear(mres),
		.in_valid(wr_tdr && fifo_ready),
		.in_ready(fifo_ready),
		.in_data(wmasked),
		.out_valid(fifo_valid),
		.out_ready(fifo_pop),
		.out_data(fifo_data)
	);

	bit_timer u_tx_timer (
		.clk(clk),
		.rst_b(rst_b),
		.tick(tx_tick),
		.restart(mres),
		.div(r.ctl.divide_select),
		.bit_en(tx_bit_en)
	);

	bit_timer u_rx_timer (
		.clk(clk),
		.rst_b(rst_b),
		.tick(rx_tick),
		.restart(rx_restart),
		.div(r.ctl.divide_select),
		.bit_en(rx_bit_en)
	);

	// ****************************************************************
	// status assembly
	// ****************************************************************
	always_comb begin
		st.receive_full_flag = r.rx_full;
		// empty only when nothing waits; cts and reset inhibit it
		st.transmit_empty_flag = !fifo_valid && !clear_to_send_b &&
			!mres;
		st.carrier_loss = r.dcd_lat || carrier_loss;
		st.clear_to_send = clear_to_send_b;
		st.framing_error_flag = r.fe;
		st.overrun_flag = r.ovr;
		st.parity_error_flag = r.pe;
		st.irq = !r.irq_b;
	end

	// ****************************************************************
	// next state
	// ****************************************************************
	always_comb begin
		s = r;
		s.en_d = bus.enable;
		s.txclk_d = tx_clk;
		s.rxclk_d = rx_clk;
		s.dcd_d = carrier_loss;
		if (wr_ctl)
			s.ctl = control_t'(bus.wdata);

		// host reads clear first, so hardware sets below win
		if (rd_stat && r.dcd_lat)
			s.dcd_armed = 1'b1;
		if (rd_rdr) begin
			if (r.ovr_pend) begin
				s.ovr = 1'b1;
				s.ovr_pend = 1'b0;
			end else begin
				s.ovr = 1'b0;
				s.rx_full = 1'b0;
			end
			if (r.dcd_armed) begin
				s.dcd_lat = 1'b0;
				s.dcd_armed = 1'b0;
			end
		end
		if (carrier_loss && !r.dcd_d) begin
			s.dcd_lat = 1'b1;
			s.dcd_armed = 1'b0;
		end

		// receiver
		case (r.rx_st)
			RX_IDLE: begin
				if (rx_tick && !rx_line) begin
					s.rx_cnt = '0;
					s.rx_st = (r.ctl.divide_select == DIV_1) ? RX_DATA :
						RX_START;
				end
			end
			RX_START: begin
				// false start: line back high at mid bit
				if (rx_bit_en)
					s.rx_st = rx_line ? RX_IDLE : RX_DATA;
			end
			RX_DATA: begin
				if (rx_bit_en) begin
					s.rx_sh = {rx_line, r.rx_sh[7:1]};
					s.rx_cnt = r.rx_cnt + 4'h1;
					if (r.rx_cnt + 4'h1 == nbits)
						s.rx_st = frm.par_en ? RX_PARITY : RX_STOP;
				end
			end
			RX_PARITY: begin
				if (rx_bit_en) begin
					s.rx_par = rx_line;
					s.rx_st = RX_STOP;
				end
			end
			RX_STOP: begin
				if (rx_bit_en) begin
					s.rx_st = RX_IDLE;
					if (r.rx_full) begin
						// character lost, sync kept
						s.ovr_pend = 1'b1;
					end else begin
						s.receive_holding_reg = rx_word;
						s.rx_full = 1'b1;
						s.fe = !rx_line;
						s.pe = frm.par_en &&
							((^rx_word) ^ r.rx_par ^ frm.par_odd);
					end
				end
			end
			default: s.rx_st = RX_IDLE;
		endcase
		if (rx_hold) begin
			s.rx_st = RX_IDLE;
			s.rx_cnt = '0;
		end
		if (carrier_loss)
			s.rx_full = 1'b0;

		// transmitter, one step per bit enable
		if (tx_bit_en) begin
			case (r.tx_st)
				TX_IDLE: s.txd = 1'b1;
				TX_START: begin
					s.txd = r.tx_sh[0];
					s.tx_sh = {1'b0, r.tx_sh[7:1]};
					s.tx_cnt = 4'h1;
					s.tx_st = TX_DATA;
				end
				TX_DATA: begin
					if (r.tx_cnt == nbits) begin
						s.tx_st = frm.par_en ? TX_PARITY : TX_STOP;
						s.txd = frm.par_en ? r.tx_par : 1'b1;
						s.tx_cnt = {2'b00, STOP_ONE};
					end else begin
						s.txd = r.tx_sh[0];
						s.tx_sh = {1'b0, r.tx_sh[7:1]};
						s.tx_cnt = r.tx_cnt + 4'h1;
					end
				end
				TX_PARITY: begin
					s.txd = 1'b1;
					s.tx_cnt = {2'b00, STOP_ONE};
					s.tx_st = TX_STOP;
				end
				TX_STOP: begin
					s.txd = 1'b1;
					if (stop_done)
						s.tx_st = TX_IDLE;
					else
						s.tx_cnt = r.tx_cnt + 4'h1;
				end
				default: s.tx_st = TX_IDLE;
			endcase
			if (tx_load) begin
				// start bit goes out now; fifo pop frees the slot
				s.tx_sh = fifo_data;
				s.tx_par = (^fifo_data) ^ frm.par_odd;
				s.txd = 1'b0;
				s.tx_st = TX_START;
			end
		end

		// master reset
		if (mres) begin
			s.rx_full = 1'b0;
			s.fe = 1'b0;
			s.pe = 1'b0;
			s.ovr = 1'b0;
			s.ovr_pend = 1'b0;
			s.dcd_lat = 1'b0;
			s.dcd_armed = 1'b0;
			s.tx_st = TX_IDLE;
			s.txd = 1'b1;
		end

		// pins
		s.tx_out = (r.ctl.tx_control == TXC_BREAK) ? 1'b0 : r.txd;
		s.rts_b = r.ctl.tx_control == TXC_HIGH_OFF;
		// conditions fall on data read or write, dropping the request
		s.irq_b = !((r.ctl.rx_interrupt_enable &&
			(r.rx_full || r.ovr || r.dcd_lat)) ||
			(r.ctl.tx_control == TXC_LOW_IRQ &&
			st.transmit_empty_flag));
		s.doe = bus.chip_sel && bus.enable && bus.read_write == DIR_READ;
		// seven bit formats read the msb as zero, even for older data
		if (bus.register_select == SEL_DATA)
			s.dout = frm.word8 ? r.receive_holding_reg :
				(r.receive_holding_reg & MASK_7BIT);
		else
			s.dout = st;
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			r <= STATE_RESET;
		else
			r <= s;
	end

	assign data_out = r.dout;
	assign data_oe = r.doe;
	assign irq_b = r.irq_b;
	assign request_to_send_b = r.rts_b;
	assign tx_line = r.tx_out;
endmodule
`default_nettype wire

//--- verification/serial_peer.sv
// serial peripheral model: free running receive clock, transmit clock stalled by hold_tx, frame send and catch
// assumes clk is the adapter's system clock; frames are lsb first
`timescale 1ns/10ps
`default_nettype none
module serial_peer (
	input wire logic clk, // system clock
	input wire logic tx_line, // adapter serial out
	output logic rx_line, // adapter serial in
	output logic tx_clk, // transmit bit clock
	output logic rx_clk, // receive bit clock
	input wire logic hold_tx // stall the transmit clock high
);
	// ****************************************************************
	// bit clocks of four cycles; hold_tx stalls the transmit clock
	// ****************************************************************
	logic [1:0] ph;
	initial begin
		ph = 2'h0;
		rx_line = 1'b1;
	end
	always @(posedge clk) begin
		ph <= #2 ph + 2'h1;
	end
	assign rx_clk = ph[1];
	assign tx_clk = ph[1] | hold_tx;
	task automatic send(input logic [11:0] b, input int n, input int p);
		logic [12:0] f;
		f = {b, 1'b0};
		for (int i = 0; i <= n; i++) begin
			rx_line = f[i];
			repeat (p) @(posedge clk);
			#2;
		end
		// back to idle only after a bad stop bit, so frames can abut
		if (rx_line !== 1'b1)
			rx_line = 1'b1;
	endtask
	// bits after the start bit, sampled mid bit; ok low if none came
	task automatic catch(input int n, input int p, output logic [11:0] b,
		output logic ok);
		int t;
		b = 12'hfff;
		t = 0;
		while (tx_line !== 1'b0 && t < 4000) begin
			@(posedge clk);
			#1;
			t++;
		end
		ok = (t < 4000);
		repeat (p / 2) @(posedge clk);
		for (int i = 0; i < n; i++) begin
			repeat (p) @(posedge clk);
			#1;
			b[i] = tx_line;
		end
		#1;
	endtask
endmodule
`default_nettype wire

//--- verification/adapter_monitor.sv
// concurrent checks on the serial adapter's pins
// assumes it is bound into async_serial_adapter; one clock domain
`timescale 1ns/10ps
`default_nettype none
module adapter_monitor (
	input wire logic clk, // system clock
	input wire logic rst_b, // async reset, active low
	input wire serial_adapter_pkg::bus_t bus, // bus pins
	input wire logic [7:0] data_out, // read data
	input wire logic data_oe, // read drive enable
	input wire logic irq_b, // interrupt, active low
	input wire logic request_to_send_b, // request pin
	input wire logic tx_line, // serial out
	input wire logic clear_to_send_b // clear to send, low = clear
);
	import serial_adapter_pkg::*;
	// ****************************************************************
	// control shadow and checks
	// ****************************************************************
	control_t ctl_r;
	logic en_r;
	logic rd_any;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ctl_r <= CONTROL_RESET;
			en_r <= 1'b0;
		end else begin
			en_r <= bus.enable;
			if (en_r && !bus.enable && bus.chip_sel && !bus.read_write &&
				bus.register_select == SEL_CTRL_STATUS) begin
				ctl_r <= control_t'(bus.wdata);
			end
		end
	end
	assign rd_any = bus.chip_sel && bus.enable && bus.read_write;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	sequence st_read(logic s);
		(rd_any && !bus.register_select && $stable(s)) [*3];
	endsequence
	rts_high_a: assert property ((ctl_r.tx_control == TXC_HIGH_OFF) [*3]
		|-> request_to_send_b) else $error("request pin not high");
	rts_low_a: assert property ((ctl_r.tx_control != TXC_HIGH_OFF) [*3]
		|-> !request_to_send_b) else $error("request pin not low");
	break_line_a: assert property ((ctl_r.tx_control == TXC_BREAK) [*3]
		|-> !tx_line) else $error("no break level");
	mreset_idle_a: assert property ((ctl_r.divide_select == DIV_MRESET &&
		ctl_r.tx_control != TXC_BREAK) [*3] |-> tx_line)
		else $error("transmitter active in reset");
	read_drive_a: assert property (rd_any |=> data_oe)
		else $error("read not driven");
	oe_cause_a: assert property (data_oe |-> $past(rd_any))
		else $error("bus driven without read");
	cts_mirror_a: assert property (st_read(clear_to_send_b)
		|=> data_out[3] == clear_to_send_b) else $error("cts bit wrong");
	cts_inhibit_a: assert property (st_read(clear_to_send_b)
		##0 clear_to_send_b |=> !data_out[1]) else $error("empty not inhibited");
	irq_bit_a: assert property (st_read(irq_b) ##1 $stable(irq_b)
		|-> data_out[7] == !irq_b) else $error("irq bit differs from pin");
	irq_off_a: assert property ((ctl_r.tx_control != TXC_LOW_IRQ &&
		!ctl_r.rx_interrupt_enable) [*3] |-> irq_b)
		else $error("irq with enables off");
	seven_bit_a: assert property (rd_any && bus.register_select &&
		!ctl_r.format_select[2] |=> !data_out[7]) else $error("msb not zero");
endmodule
bind async_serial_adapter adapter_monitor mon (.clk, .rst_b, .bus,
	.data_out, .data_oe, .irq_b, .request_to_send_b, .tx_line,
	.clear_to_send_b);
`default_nettype wire

//--- verification/test_async_serial_adapter.sv
// register level testbench of the serial adapter with a serial peer
// assumes serial_peer and adapter_monitor are compiled alongside
`timescale 1ns/10ps
`default_nettype none
module test_async_serial_adapter;
	import serial_adapter_pkg::*;
	// ****************************************************************
	// harness, bus tasks and checks
	// ****************************************************************
	logic clk, rst_b, data_oe, irq_b, rts_b, tx_line, rx_line;
	logic tx_clk, rx_clk, cts_b, cl, hold_tx;
	logic [7:0] data_out;
	bus_t bus;
	int fails = 0;
	int checks_done = 0;
	async_serial_adapter dut (.clk(clk), .rst_b(rst_b), .bus(bus),
		.data_out(data_out), .data_oe(data_oe), .irq_b(irq_b),
		.request_to_send_b(rts_b), .tx_line(tx_line), .rx_line(rx_line),
		.tx_clk(tx_clk), .rx_clk(rx_clk), .clear_to_send_b(cts_b),
		.carrier_loss(cl));
	serial_peer peer (.clk(clk), .tx_line(tx_line), .rx_line(rx_line),
		.tx_clk(tx_clk), .rx_clk(rx_clk), .hold_tx(hold_tx));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task automatic step();
		@(posedge clk);
		#2;
	endtask
	task automatic acc(input logic rs, input logic rw, input logic [7:0] w,
		output logic [7:0] r);
		bus = '{1'b1, rs, rw, 1'b1, w};
		repeat (3) step();
		r = data_out;
		bus.enable = 1'b0;
		repeat (2) step();
		bus.chip_sel = 1'b0;
		repeat (2) step();
	endtask
	task automatic chk(input string s, input logic [11:0] e,
		input logic [11:0] g);
		checks_done++;
		if (g !== e) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic chk_bit(input string s, input logic e, input logic g);
		chk(s, {11'h0, e}, {11'h0, g});
	endtask
	task automatic st(input logic [7:0] e);
		logic [7:0] r;
		acc(SEL_CTRL_STATUS, DIR_READ, 8'h00, r);
		chk("status", {4'h0, e}, {4'h0, r});
	endtask
	task automatic rd(input logic [7:0] e);
		logic [7:0] r;
		acc(SEL_DATA, DIR_READ, 8'h00, r);
		chk("rx data", {4'h0, e}, {4'h0, r});
	endtask
	task automatic wr(input logic rs, input logic [7:0] v);
		logic [7:0] r;
		acc(rs, DIR_WRITE, v, r);
	endtask
	// serial bits after start: data, parity, stops
	function automatic logic [11:0] frame(input logic [2:0] f,
		input logic [7:0] d, output int n);
		logic [11:0] b;
		b = f[2] ? {4'hf, d} : {5'h1f, d[6:0]};
		n = f[2] ? 8 : 7;
		if (!(f == 3'h4 || f == 3'h5)) begin
			b[n] = ^(f[2] ? d : {1'b0, d[6:0]}) ^ f[0];
			n++;
		end
		n = n + ((f == 3'h0 || f == 3'h1 || f == 3'h4) ? 2 : 1);
		return b;
	endfunction
	task automatic endt(input string s);
		$display("test %s done: checks %0d mismatches %0d", s,
			checks_done, fails);
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	initial begin
		logic [11:0] e, g;
		logic ok;
		logic [7:0] r;
		int n;
		bus = '0;
		hold_tx = 1'b0;
		cts_b = 1'b0;
		cl = 1'b0;
		rst_b = 1'b0;
		repeat (4) @(posedge clk);
		#2 rst_b = 1'b1;
		step();
		st(8'h00);
		wr(SEL_CTRL_STATUS, 8'h03);
		wr(SEL_CTRL_STATUS, 8'h15);
		st(8'h02);
		cts_b = 1'b1;
		st(8'h08);
		cts_b = 1'b0;
		wr(SEL_CTRL_STATUS, 8'h55);
		chk_bit("request", 1'b1, rts_b);
		wr(SEL_CTRL_STATUS, 8'h75);
		chk_bit("request", 1'b0, rts_b);
		chk_bit("break", 1'b0, tx_line);
		endt("control");
		for (int f = 0; f < 9; f++) begin
			wr(SEL_CTRL_STATUS, f < 8 ? {3'h0, f[2:0], DIV_16} : 8'h16);
			wr(SEL_DATA, 8'hd3);
			e = frame(f < 8 ? f[2:0] : 3'h5, 8'hd3, n);
			peer.catch(n, f < 8 ? 64 : 256, g, ok);
			chk_bit("frame seen", 1'b1, ok);
			chk("tx frame", e, g);
		end
		endt("formats");
		wr(SEL_CTRL_STATUS, 8'h34);
		chk_bit("irq", 1'b0, irq_b);
		hold_tx = 1'b1;
		for (int i = 0; i < 17; i++) wr(SEL_DATA, 8'h40 + i[7:0]);
		chk_bit("irq", 1'b1, irq_b);
		st(8'h00);
		hold_tx = 1'b0;
		for (int i = 0; i < 17; i++) begin
			e = frame(3'h5, 8'h40 + i[7:0], n);
			peer.catch(n, 4, g, ok);
			chk_bit("frame seen", i < 16, ok);
			if (i < 16) chk("fifo frame", e, g);
		end
		st(8'h82);
		endt("fifo");
		wr(SEL_CTRL_STATUS, 8'h15);
		e = frame(3'h5, 8'h3c, n);
		peer.send(e, n, 64);
		st(8'h03);
		rd(8'h3c);
		st(8'h02);
		peer.send(e & 12'heff, n, 64);
		st(8'h13);
		rd(8'h3c);
		peer.send(e, n, 64);
		g = frame(3'h5, 8'h5a, n);
		peer.send(g, n, 64);
		st(8'h03);
		rd(8'h3c);
		st(8'h23);
		rd(8'h3c);
		st(8'h02);
		wr(SEL_CTRL_STATUS, 8'h09);
		g = frame(3'h2, 8'h3c, n);
		peer.send(g ^ 12'h080, n, 64);
		st(8'h43);
		rd(8'h3c);
		wr(SEL_CTRL_STATUS, 8'h15);
		peer.send(e, n, 64);
		wr(SEL_CTRL_STATUS, 8'h17);
		cts_b = 1'b1;
		st(8'h08);
		cts_b = 1'b0;
		wr(SEL_CTRL_STATUS, 8'h15);
		st(8'h02);
		endt("receive");
		wr(SEL_CTRL_STATUS, 8'h95);
		peer.send(e, n, 64);
		st(8'h83);
		chk_bit("irq", 1'b0, irq_b);
		cl = 1'b1;
		step();
		cl = 1'b0;
		st(8'h86);
		acc(SEL_DATA, DIR_READ, 8'h00, r);
		chk_bit("irq", 1'b1, irq_b);
		st(8'h02);
		cl = 1'b1;
		step();
		st(8'h86);
		acc(SEL_DATA, DIR_READ, 8'h00, r);
		st(8'h06);
		chk_bit("irq", 1'b1, irq_b);
		cl = 1'b0;
		step();
		st(8'h02);
		endt("carrier");
		wrap_up();
	end
endmodule
`default_nettype wire
